// ===== src/fep_pkg.sv
// package: shared constants and state types of the fast ethernet coding datapath
package fep_pkg;
   // ==========================================================
   // host link and datapath widths
   localparam int HOST_LANES = 3; // bits per host transfer
   localparam int NIB_W = 4; // data nibble
   localparam int SYM_W = 5; // line code group
   localparam int FIFO_DEPTH = 8; // transmit nibble buffer
   localparam int LVL_W = 2; // three-level line code width

   // ==========================================================
   // 5b code groups
   localparam logic [4:0] SYM_IDLE = 5'h1f; // inter packet idle
   localparam logic [4:0] SYM_J = 5'h18; // first start code
   localparam logic [4:0] SYM_K = 5'h11; // second start code
   localparam logic [4:0] SYM_T = 5'h0d; // first end code
   localparam logic [4:0] SYM_R = 5'h07; // second end code
   localparam logic [3:0] PRE_NIB = 4'h5; // nibble that J and K stand for
   // data nibble 0..f to code group
   localparam logic [4:0] ENC_TBL [16] = '{
      5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

   // ==========================================================
   // scrambler
   localparam int SCR_W = 11; // key register length
   localparam int SCR_TAP_A = 10; // holds x[n-11]
   localparam int SCR_TAP_B = 8; // holds x[n-9]
   localparam logic [10:0] SCR_SEED = 11'h7ff; // any nonzero seed works
   localparam int LOCK_BITS_DEF = 60; // idle bits that confirm descrambler lock
   localparam int LOCK_CNT_W = 7; // wide enough for the lock count

   // ==========================================================
   // three-level line code
   localparam logic [1:0] LVL_ZERO = 2'h0;
   localparam logic [1:0] LVL_POS = 2'h1;
   localparam logic [1:0] LVL_NEG = 2'h3;
   localparam logic [1:0] MLT_IDX_RST = 2'h1; // cycle index of the zero before positive

   // ==========================================================
   // rates and times
   localparam int SYS_CLK_MHZ = 50;
   localparam int TX100_MBPS = 125; // serial rate carried by the tick in fast mode
   localparam int MANCH_CLK_MHZ = 20; // half-bit rate in slow mode
   localparam int HALF_BIT_NS = 1000 / MANCH_CLK_MHZ;
   localparam int NARROW_PULSE_NS = 50;
   localparam int WIDE_PULSE_NS = 100;
   // halves of full drive at the start of any pulse, rounded up
   localparam int NARROW_HALVES = (NARROW_PULSE_NS + HALF_BIT_NS - 1) / HALF_BIT_NS;
   localparam int WIDE_HALVES = WIDE_PULSE_NS / HALF_BIT_NS;

   // ==========================================================
   // state types
   typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_st_t;
   typedef enum logic [2:0] {RX_IDLE, RX_J, RX_K, RX_DATA, RX_TEND} fep_rx_st_t;
endpackage : fep_pkg

// ===== src/fep_fifo.sv
// module: synchronous valid/ready fifo used in the transmit nibble path
`timescale 1ns/1ps
module fep_fifo #(
   parameter int W = 5, // entry width
   parameter int DEPTH = 8 // entries, power of two
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // fill side
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   // drain side
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   // ==========================================================
   // storage and pointers
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH]; // entries
   logic [AW-1:0] wp_r; // write pointer, wraps because depth is a power of two
   logic [AW-1:0] rp_r; // read pointer
   logic [AW:0] cnt_r; // fill level

   wire wr = i_in_valid && o_in_ready;
   wire rd = o_out_valid && i_out_ready;
   assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data = mem[rp_r];

   // ==========================================================
   // pointer and level update
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (wr) wp_r <= wp_r + 1'b1;
         if (rd) rp_r <= rp_r + 1'b1;
         if (wr && !rd) cnt_r <= cnt_r + 1'b1;
         else if (rd && !wr) cnt_r <= cnt_r - 1'b1;
      end
   end

   // entry write, no reset needed on data
   always_ff @(posedge i_sys_clk) begin
      if (wr) mem[wp_r] <= i_in_data;
   end
endmodule : fep_fifo

// ===== src/fep_coding_top.sv
// module: 10/100 line coding datapath between the host link and the line
// Notes on behaviour
// (RL1) take three host bits per transfer, pass on
// (RL2) data nibble maps to fixed 5b code
// (RL3) idle code between packets carries no data
// (RL4) start pair J then K replaces 0101
// (RL5) end pair T then R
// (RL6) first preamble byte becomes J K, rest encoded
// (RL7) after last nibble append T R, then idle
// (RL8) scramble every code bit toward three-level coder
// (RL9) key bit is x[n-11] xor x[n-9]
// (RL10) serialize codes at the fast serial rate
// (RL11) three-level output holds on a zero bit
// (RL12) one bit steps negative zero positive zero
// (RL13) descrambler locks onto remote key during idle
// (RL14) decode received codes back into nibbles
// (RL15) invalid received code raises error
// (RL16) link loss during a frame raises error
// (RL17) incomplete J K after idle raises error
// (RL18) idle inside frame before T R errors
// (RL19) slow mode: nibbles serialized, then manchester halves
// (RL20) mid-bit transition always, boundary only when equal
// (RL21) lower drive in second half of wide pulses
// (RL22) slow mode received bits delivered as nibbles
// (RL23) host pulses sync one cycle; longer means reset
// (RL24) reset: nonzero seed, zero level, idle codes
`timescale 1ns/1ps
module fep_coding_top #(
   parameter int LOCK_BITS = fep_pkg::LOCK_BITS_DEF // idle bits to declare lock
) (
   // clock, reset and mode
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_speed_100, // high for fast mode, change only under reset
   // host transmit side
   input wire logic i_host_reset_sync_line,
   input wire logic i_host_tx_en,
   input wire logic i_host_tx_valid,
   input wire logic [fep_pkg::HOST_LANES-1:0] i_host_tx_lanes,
   output logic o_host_tx_ready,
   // line transmit side
   input wire logic i_tx_tick, // one serial bit (fast) or half-bit (slow)
   output logic [fep_pkg::LVL_W-1:0] o_tx_level,
   output logic o_tx_active,
   output logic o_manch_out,
   output logic o_drive_full,
   // line receive side
   input wire logic i_rx_tick,
   input wire logic [fep_pkg::LVL_W-1:0] i_rx_level,
   input wire logic i_link_ok,
   input wire logic i_rx_half,
   input wire logic i_rx_carrier,
   // host receive side
   output logic [fep_pkg::NIB_W-1:0] o_rx_nibble,
   output logic o_rx_valid,
   output logic o_rx_frame,
   output logic o_rx_err,
   output logic o_rx_locked
);
   import fep_pkg::*;

   // ==========================================================
   // reset and word synchronisation
   logic sync_d_r; // last cycle's sync line
   // a second consecutive high cycle turns the sync into a reset
   wire rst_w = i_reset || (i_host_reset_sync_line && sync_d_r); // [RL23]
   wire sync_pulse = i_host_reset_sync_line && !sync_d_r;

   // sync line history, reset by the pin only
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) sync_d_r <= 1'b0;
      else sync_d_r <= i_host_reset_sync_line;
   end

   // ==========================================================
   // host bits to nibbles
   logic [6:0] acc_r, acc_nxt; // bits not yet packed, lsb first
   logic [2:0] cnt_r, cnt_nxt; // number of bits held
   logic en_d_r; // host frame enable, delayed
   logic first_r; // next nibble opens a frame
   logic fifo_rdy; // buffer can take a nibble
   wire take = i_host_tx_valid && o_host_tx_ready; // [RL1]
   wire [6:0] acc_in = take ? (acc_r | ({4'h0, i_host_tx_lanes} << cnt_r)) : acc_r;
   wire [2:0] cnt_in = take ? cnt_r + 3'd3 : cnt_r;
   wire push = (cnt_in >= 3'd4) && fifo_rdy;
   assign acc_nxt = push ? {4'h0, acc_in[6:4]} : acc_in;
   assign cnt_nxt = push ? cnt_in - 3'd4 : cnt_in;

   // packer; the ready output stalls the host while a full nibble waits
   always_ff @(posedge i_sys_clk) begin
      if (rst_w || sync_pulse) begin
         acc_r <= '0;
         cnt_r <= '0;
         o_host_tx_ready <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         cnt_r <= cnt_nxt;
         o_host_tx_ready <= (cnt_nxt < 3'd4);
      end
   end

   // frame start tag; a new frame edge wins over a push clear
   always_ff @(posedge i_sys_clk) begin
      if (rst_w) begin
         en_d_r <= 1'b0;
         first_r <= 1'b0;
      end else begin
         en_d_r <= i_host_tx_en;
         if (i_host_tx_en && !en_d_r) first_r <= 1'b1;
         else if (push) first_r <= 1'b0;
      end
   end

   // ==========================================================
   // transmit buffer
   logic fv; // a nibble waits
   logic [NIB_W:0] fdat; // {frame start tag, nibble}
   logic pop; // nibble consumed
   fep_fifo #(.W(NIB_W + 1), .DEPTH(FIFO_DEPTH)) u_txbuf (
      .i_sys_clk(i_sys_clk),
      .i_reset(rst_w),
      .i_in_valid(push),
      .i_in_data({first_r, acc_in[3:0]}),
      .o_in_ready(fifo_rdy),
      .o_out_valid(fv),
      .o_out_data(fdat),
      .i_out_ready(pop)
   );
   wire ftag = fdat[NIB_W];
   wire [3:0] fnib = fdat[3:0];

   // ==========================================================
   // transmit framer and code selection
   fep_tx_st_t txs_r, txs_nxt; // framer state
   logic [4:0] sh_r; // code group sent msb first, or nibble sent lsb first
   logic [2:0] bcnt_r; // bit (fast) or half-bit (slow) position
   logic [4:0] sym_sel; // next code group
   logic pop100; // framer wants the head nibble
   wire tick100 = i_tx_tick && i_speed_100;
   wire tick10 = i_tx_tick && !i_speed_100;
   wire load100 = tick100 && (bcnt_r == 3'd4); // [RL10]

   // next code group; only used on a group boundary
   always_comb begin
      sym_sel = SYM_IDLE; // [RL3]
      txs_nxt = txs_r;
      pop100 = 1'b0;
      case (txs_r)
         TX_IDLE: begin
            if (fv && ftag) begin
               sym_sel = SYM_J; // [RL4] [RL6]
               pop100 = 1'b1;
               txs_nxt = TX_K;
            end
         end
         TX_K: begin
            sym_sel = SYM_K; // [RL4] [RL6]
            pop100 = fv;
            txs_nxt = TX_DATA;
         end
         TX_DATA: begin
            // a missing nibble or a new frame tag ends this frame
            if (fv && !ftag) begin
               sym_sel = ENC_TBL[fnib]; // [RL2] [RL6]
               pop100 = 1'b1;
            end else begin
               sym_sel = SYM_T; // [RL5] [RL7]
               txs_nxt = TX_R;
            end
         end
         TX_R: begin
            sym_sel = SYM_R; // [RL5] [RL7]
            txs_nxt = TX_IDLE;
         end
         default: txs_nxt = TX_IDLE;
      endcase
   end

   // ==========================================================
   // scrambler and three-level coder
   logic [SCR_W-1:0] lfsr_r; // last eleven key bits, bit 0 newest
   logic [1:0] lidx_r; // position in the level cycle
   wire key = lfsr_r[SCR_TAP_A] ^ lfsr_r[SCR_TAP_B]; // [RL9]
   wire sbit = sh_r[4] ^ key; // [RL8]
   wire [1:0] lidx_nxt = sbit ? lidx_r + 2'd1 : lidx_r; // [RL11] [RL12]
   // cycle index 0..3 is negative, zero, positive, zero
   wire [1:0] lvl_nxt = lidx_nxt[0] ? LVL_ZERO : (lidx_nxt[1] ? LVL_POS : LVL_NEG);

   // ==========================================================
   // slow mode half-bit coder
   logic active_r; // slow mode nibble in flight
   logic [1:0] run_r; // halves since the last level change
   wire b10 = sh_r[bcnt_r[2:1]]; // nibble bits go out lsb first
   wire manch_nxt = bcnt_r[0] ? b10 : ~b10; // [RL20]
   wire same_half = (manch_nxt == o_manch_out);
   wire [1:0] run_nxt = same_half ? run_r + 2'd1 : 2'd0;
   wire load10 = tick10 && (!active_r || bcnt_r == 3'd7); // [RL19]
   assign pop = i_speed_100 ? (load100 && pop100) : (load10 && fv);

   // transmit state, code shifting, scrambler and level registers
   always_ff @(posedge i_sys_clk) begin
      if (rst_w) begin
         txs_r <= TX_IDLE; // [RL24]
         sh_r <= SYM_IDLE;
         bcnt_r <= '0;
         lfsr_r <= SCR_SEED;
         lidx_r <= MLT_IDX_RST;
         o_tx_level <= LVL_ZERO;
         active_r <= 1'b0;
         run_r <= '0;
         o_manch_out <= 1'b0;
         o_drive_full <= 1'b0;
         o_tx_active <= 1'b0;
      end else if (tick100) begin
         // one serial bit leaves per tick, a new group every fifth
         lfsr_r <= {lfsr_r[SCR_W-2:0], key};
         lidx_r <= lidx_nxt;
         o_tx_level <= lvl_nxt;
         o_tx_active <= 1'b1;
         o_drive_full <= 1'b1;
         if (load100) begin
            sh_r <= sym_sel;
            txs_r <= txs_nxt;
            bcnt_r <= '0;
         end else begin
            sh_r <= {sh_r[3:0], 1'b0};
            bcnt_r <= bcnt_r + 3'd1;
         end
      end else if (tick10) begin
         if (active_r) begin
            o_manch_out <= manch_nxt;
            run_r <= run_nxt;
            // full drive only at the start of a level; wide pulses droop
            o_drive_full <= (run_nxt < 2'(NARROW_HALVES)); // [RL21]
         end
         if (load10) begin
            sh_r <= {1'b0, fnib};
            bcnt_r <= '0;
            active_r <= fv;
            o_tx_active <= fv;
         end else begin
            bcnt_r <= bcnt_r + 3'd1;
         end
      end
   end

   // ==========================================================
   // receive: level decode and descrambler lock
   logic [1:0] rlvl_r; // previous received level
   logic [SCR_W-1:0] dl_r; // local copy of the remote key
   logic [LOCK_CNT_W-1:0] mcnt_r; // consecutive idle bits seen
   wire rev_bit = i_rx_tick && i_speed_100;
   wire rnrz = (i_rx_level != rlvl_r); // any level change is a one
   wire rkey = dl_r[SCR_TAP_A] ^ dl_r[SCR_TAP_B];
   wire rplain = rnrz ^ rkey;
   wire lock_hit = rplain && (mcnt_r == LOCK_CNT_W'(LOCK_BITS - 1));

   // idle is all ones, so an unlocked receiver loads the inverted line bits
   // as key; once the guess is right the prediction keeps matching
   always_ff @(posedge i_sys_clk) begin
      if (rst_w) begin
         rlvl_r <= LVL_ZERO;
         dl_r <= '0;
         mcnt_r <= '0;
         o_rx_locked <= 1'b0;
      end else begin
         if (rev_bit) rlvl_r <= i_rx_level;
         if (!i_link_ok) begin
            mcnt_r <= '0;
            o_rx_locked <= 1'b0;
         end else if (rev_bit && o_rx_locked) begin
            dl_r <= {dl_r[SCR_W-2:0], rkey};
         end else if (rev_bit) begin
            dl_r <= {dl_r[SCR_W-2:0], ~rnrz}; // [RL13]
            mcnt_r <= rplain ? mcnt_r + 1'b1 : '0;
            o_rx_locked <= lock_hit; // [RL13]
         end
      end
   end

   // ==========================================================
   // receive: code group framing and decode
   fep_rx_st_t rs_r, rs_nxt; // receive framing state
   logic [2:0] rem_r, rem_nxt; // bits left in the current group
   logic [9:0] win_r; // descrambled bits, newest in bit 0
   logic dlv100; // deliver a nibble
   logic [3:0] dnib100; // nibble to deliver
   logic err100; // framing or code error
   logic dok; // group is a data code
   logic [3:0] dval; // its nibble
   wire rev = rev_bit && o_rx_locked;
   wire [9:0] win_nxt = {win_r[8:0], rplain};
   wire [4:0] grp = win_nxt[4:0];

   // reverse table search
   always_comb begin
      dok = 1'b0;
      dval = '0;
      for (int i = 0; i < 16; i++) begin
         if (ENC_TBL[i] == grp) begin
            dok = 1'b1; // [RL14]
            dval = 4'(i);
         end
      end
   end

   // framing: the first zero after idle is the third bit of J
   always_comb begin
      rs_nxt = rs_r;
      rem_nxt = rem_r;
      dlv100 = 1'b0;
      dnib100 = dval;
      err100 = 1'b0;
      if (!i_link_ok && rs_r != RX_IDLE) begin
         err100 = 1'b1; // [RL16]
         rs_nxt = RX_IDLE;
      end else if (rev) begin
         rem_nxt = rem_r - 3'd1;
         case (rs_r)
            RX_IDLE: begin
               if (!rplain) begin
                  rs_nxt = RX_J;
                  rem_nxt = 3'd2;
               end
            end
            RX_J: begin
               if (rem_r == 3'd1) begin
                  rs_nxt = (grp == SYM_J) ? RX_K : RX_IDLE;
                  err100 = (grp != SYM_J); // [RL17]
                  dlv100 = (grp == SYM_J);
                  dnib100 = PRE_NIB;
                  rem_nxt = 3'd5;
               end
            end
            RX_K: begin
               if (rem_r == 3'd1) begin
                  rs_nxt = (grp == SYM_K) ? RX_DATA : RX_IDLE;
                  err100 = (grp != SYM_K); // [RL17]
                  dlv100 = (grp == SYM_K);
                  dnib100 = PRE_NIB;
                  rem_nxt = 3'd5;
               end
            end
            RX_DATA: begin
               if (rem_r == 3'd1) begin
                  rem_nxt = 3'd5;
                  if (grp == SYM_T) begin
                     rs_nxt = RX_TEND;
                  end else if (dok) begin
                     dlv100 = 1'b1; // [RL14]
                  end else begin
                     err100 = 1'b1; // [RL15] [RL18]
                     rs_nxt = RX_IDLE;
                  end
               end
            end
            RX_TEND: begin
               if (rem_r == 3'd1) begin
                  err100 = (grp != SYM_R);
                  rs_nxt = RX_IDLE;
               end
            end
            default: rs_nxt = RX_IDLE;
         endcase
      end
   end

   // ==========================================================
   // receive: slow mode half-bit pairing
   logic ph_r; // second half of a bit expected
   logic [1:0] bi_r; // bit index within the nibble
   logic [2:0] nb_r; // bits gathered so far
   wire dlv10 = i_rx_tick && i_rx_carrier && ph_r && (bi_r == 2'd3); // [RL22]

   // the second half of each bit carries its value
   always_ff @(posedge i_sys_clk) begin
      if (rst_w || !i_rx_carrier) begin
         ph_r <= 1'b0;
         bi_r <= '0;
         nb_r <= '0;
      end else if (i_rx_tick && !i_speed_100) begin
         ph_r <= !ph_r;
         if (ph_r) begin
            bi_r <= bi_r + 2'd1;
            if (bi_r != 2'd3) nb_r[bi_r] <= i_rx_half;
         end
      end
   end

   // receive framing registers and host outputs
   always_ff @(posedge i_sys_clk) begin
      if (rst_w) begin
         rs_r <= RX_IDLE;
         rem_r <= '0;
         win_r <= '0;
         o_rx_nibble <= '0;
         o_rx_valid <= 1'b0;
         o_rx_err <= 1'b0;
         o_rx_frame <= 1'b0;
      end else if (i_speed_100) begin
         rs_r <= rs_nxt;
         rem_r <= rem_nxt;
         if (rev) win_r <= win_nxt;
         o_rx_valid <= dlv100;
         if (dlv100) o_rx_nibble <= dnib100;
         o_rx_err <= err100;
         o_rx_frame <= (rs_nxt != RX_IDLE);
      end else begin
         o_rx_valid <= dlv10;
         if (dlv10) o_rx_nibble <= {i_rx_half, nb_r};
         o_rx_err <= 1'b0;
         o_rx_frame <= i_rx_carrier;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (rst_w);

   sequence s_frame_open;
      load100 && txs_r == TX_IDLE && fv && ftag;
   endsequence
   sequence s_j_out;
      sh_r == SYM_J && txs_r == TX_K;
   endsequence

   a_start_pair: assert property (s_frame_open |=> s_j_out) // [RL4]
      else $error("start code J not loaded");
   a_k_follows: assert property (load100 && txs_r == TX_K |=> sh_r == SYM_K ##0 txs_r == TX_DATA) // [RL4]
      else $error("K did not follow J");
   a_end_pair: assert property (load100 && txs_r == TX_R |=> sh_r == SYM_R && txs_r == TX_IDLE) // [RL7]
      else $error("R did not follow T");
   a_idle_fill: assert property (load100 && txs_r == TX_IDLE && !(fv && ftag) |=> sh_r == SYM_IDLE) // [RL3]
      else $error("idle code missing between packets");
   a_mlt_hold: assert property (tick100 && !sbit |=> $stable(o_tx_level)) // [RL11]
      else $error("line level moved on a zero bit");
   a_mlt_step: assert property (tick100 && sbit |=> lidx_r == 2'($past(lidx_r) + 2'd1)) // [RL12]
      else $error("line level did not step on a one bit");
   a_scr_key: assert property (tick100 |=> lfsr_r[0] == ($past(lfsr_r[10]) ^ $past(lfsr_r[8]))) // [RL9]
      else $error("scrambler key sequence wrong");
   a_scr_live: assert property (lfsr_r != '0) // [RL24]
      else $error("scrambler register reached zero");
   a_rx_badcode: assert property (rev && rs_r == RX_DATA && rem_r == 3'd1 && !dok && grp != SYM_T
      |=> o_rx_err && rs_r == RX_IDLE) // [RL15]
      else $error("invalid code not flagged");
   a_rx_linkloss: assert property (!i_link_ok && rs_r != RX_IDLE |=> o_rx_err ##1 !o_rx_frame) // [RL16]
      else $error("link loss in frame not flagged");
   a_manch_mid: assert property (tick10 && active_r && bcnt_r[0] |-> manch_nxt != o_manch_out) // [RL20]
      else $error("no mid-bit transition");
   a_drive_cut: assert property (tick10 && active_r && same_half |=> !o_drive_full) // [RL21]
      else $error("full drive held in second half of wide pulse");
endmodule : fep_coding_top

// ===== test/fep_mac_model.sv
// file: host link model of the mac that feeds transmit bits
`timescale 1ns/1ps
module fep_mac_model (
   // clock and handshake
   input wire logic i_sys_clk,
   input wire logic i_ready,
   // host link drive
   output logic o_sync,
   output logic o_en,
   output logic o_valid,
   output logic [2:0] o_lanes
);
   initial begin
      o_sync = 1'b0;
      o_en = 1'b0;
      o_valid = 1'b0;
      o_lanes = 3'h0;
   end
   // ==========================================================
   // word sync: one cycle only, a second cycle would reset the device
   task automatic sync_pulse();
      @(negedge i_sys_clk) o_sync = 1'b1;
      @(negedge i_sys_clk) o_sync = 1'b0;
   endtask : sync_pulse
   // ==========================================================
   // held until ready is seen high; slow mode idles a cycle with junk lanes
   task automatic send(input logic [95:0] bits, input int ntr, input bit slow, output bit hung);
      int w;
      hung = 0;
      @(negedge i_sys_clk) o_en = 1'b1;
      for (int i = 0; i < ntr; i++) begin
         o_valid = 1'b1;
         o_lanes = bits[3*i+:3];
         for (w = 0; !i_ready && w < 64; w++) @(negedge i_sys_clk);
         hung |= (w == 64);
         @(negedge i_sys_clk);
         if (slow) begin
            o_valid = 1'b0;
            o_lanes = ~o_lanes;
            @(negedge i_sys_clk);
         end
      end
      o_valid = 1'b0;
      o_en = 1'b0;
      o_lanes = ~o_lanes;
   endtask : send
endmodule : fep_mac_model

// ===== test/testbench.sv
// file: self-checking loopback bench of the fast and slow mode coding paths
`timescale 1ns/1ps
module testbench;
   import fep_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic tx_tick = 1'b0;
   logic rx_tick = 1'b0;
   logic link_ok = 1'b1;
   logic tick_seen = 1'b0;
   logic speed = 1'b1, car = 1'b0; // mode pin, carrier
   logic run = 1'b0;
   logic sync, en, valid, ready, rx_valid, rx_frame, rx_err, locked, active, drive_full, manch;
   logic [2:0] lanes;
   logic [1:0] level, prev_lvl, last_nz;
   logic [3:0] nibble;
   logic [7:0] exp_q[$]; // nibbles the receive side must deliver
   logic [15:0] lfsr = 16'hc6e9;
   int errors = 0;
   int check_count = 0;
   // next level of the negative, zero, positive, zero cycle
   wire logic [1:0] step_lvl = (prev_lvl != LVL_ZERO) ? LVL_ZERO :
      (last_nz == LVL_NEG) ? LVL_POS : LVL_NEG;
   always #10 i_sys_clk = ~i_sys_clk;
   // line pacing: a tick every other cycle, receive one cycle behind
   always @(negedge i_sys_clk) begin
      tx_tick <= ~tx_tick;
      rx_tick <= tx_tick;
   end
   always @(posedge i_sys_clk) tick_seen <= tx_tick;
   // carrier one tick late
   always @(posedge i_sys_clk) if (tx_tick) car <= active;
   fep_mac_model mac (.i_sys_clk(i_sys_clk), .i_ready(ready), .o_sync(sync), .o_en(en),
      .o_valid(valid), .o_lanes(lanes));
   fep_coding_top #(.LOCK_BITS(16)) DUT (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_speed_100(speed), .i_host_reset_sync_line(sync), .i_host_tx_en(en),
      .i_host_tx_valid(valid), .i_host_tx_lanes(lanes), .o_host_tx_ready(ready),
      .i_tx_tick(tx_tick), .o_tx_level(level), .o_tx_active(active), .o_manch_out(manch),
      .o_drive_full(drive_full), .i_rx_tick(rx_tick), .i_rx_level(level), .i_link_ok(link_ok),
      .i_rx_half(manch), .i_rx_carrier(car), .o_rx_nibble(nibble), .o_rx_valid(rx_valid),
      .o_rx_frame(rx_frame), .o_rx_err(rx_err), .o_rx_locked(locked));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      check_count++;
      if (seen !== expv) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, expv);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // a wait that used its whole bound ends the run
   task automatic give_up(input int w, input int lim);
      if (w >= lim) begin
         errors++;
         final_report();
      end
   endtask : give_up
   // ==========================================================
   // model of the delivered stream and of the level stepping
   always @(negedge i_sys_clk) begin
      if (run) begin
         if (rx_valid === 1'b1) check({4'h0, nibble}, exp_q.size() ? exp_q.pop_front() : 8'hee);
         if (rx_err !== 1'b0) check({7'h0, rx_err}, 8'h00);
         if (level !== prev_lvl) begin
            check({tick_seen, 5'h0, level}, {1'b1, 5'h0, step_lvl});
            if (level != LVL_ZERO) last_nz = level;
         end
         prev_lvl = level;
      end
   end
   // ==========================================================
   // main sequence: lock on idle, random frames, link loss in the last
   initial begin
      logic [95:0] bits;
      int g;
      int w;
      bit hung;
      repeat (8) @(negedge i_sys_clk);
      i_reset <= 1'b0;
      prev_lvl = LVL_ZERO;
      last_nz = LVL_NEG;
      run = 1'b1;
      @(negedge i_sys_clk);
      check({7'h0, ready}, 8'h01);
      for (w = 0; locked !== 1'b1 && w < 4000; w++) @(negedge i_sys_clk);
      give_up(w, 4000);
      check({6'h0, active, drive_full}, 8'h03);
      mac.sync_pulse();
      for (int f = 0; f < 6; f++) begin
         lfsr = lfsr_next(lfsr);
         g = (f == 5) ? 8 : 1 + int'(lfsr[2:0]);
         bits = '0;
         exp_q.push_back(8'h05);
         exp_q.push_back(8'h05);
         for (int k = 0; k < 3 * g; k++) begin
            lfsr = lfsr_next(lfsr);
            bits[4*k+:4] = lfsr[3:0];
            if (k > 1) exp_q.push_back({4'h0, lfsr[3:0]});
         end
         mac.send(bits, 4 * g, lfsr[5], hung);
         give_up(int'(hung), 1);
         if (f < 5) begin
            for (w = 0; (exp_q.size() || rx_frame !== 1'b0) && w < 3000; w++) @(negedge i_sys_clk);
            give_up(w, 3000);
         end
      end
      // last frame still on the line: drop the link for one cycle
      for (w = 0; rx_frame !== 1'b1 && w < 500; w++) @(negedge i_sys_clk);
      give_up(w, 500);
      run = 1'b0;
      link_ok <= 1'b0;
      w = 0;
      repeat (3) begin
         @(negedge i_sys_clk);
         link_ok <= 1'b1;
         w += int'(rx_err === 1'b1);
      end
      check({7'h0, w != 0}, 8'h01);
      // slow mode after a second reset
      speed <= 1'b0;
      i_reset <= 1'b1;
      repeat (8) @(negedge i_sys_clk);
      i_reset <= 1'b0;
      exp_q.delete();
      prev_lvl = LVL_ZERO;
      run = 1'b1;
      @(negedge i_sys_clk);
      check({5'h0, ready, active, drive_full}, 8'h04);
      for (int k = 0; k < 6; k++) begin
         lfsr = lfsr_next(lfsr);
         bits[4*k+:4] = lfsr[3:0];
         exp_q.push_back({4'h0, lfsr[3:0]});
      end
      mac.send(bits, 8, lfsr[5], hung);
      give_up(int'(hung), 1);
      for (w = 0; (exp_q.size() || rx_frame !== 1'b0) && w < 3000; w++) @(negedge i_sys_clk);
      give_up(w, 3000);
      final_report();
   end
endmodule : testbench
